// >>> core/ppc_pin_share.sv
/*
  Pin-sharing control for the forty general-purpose port pins: data and
  direction registers, peripheral enable mirrors and the per-pin owner
  mux. Assumes an AHB-Lite master issuing single word transfers with
  an idle cycle between transfers, pins arriving asynchronously.
*/
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.

module ppc_pin_share (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [39:0] padIn,
  output logic [39:0] padOut,
  output logic [39:0] padOeN,
  input wire logic [39:0] periphDrive,
  input wire logic [39:0] periphDriveEn,
  output logic [39:0] pinLevel,
  output logic [39:0] periphOwn
);

  ////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] dataLatch_reg [5];
  logic [7:0] dir_reg [5];
  ppc_pkg::ppc_cfg_t cfg_reg;
  logic wrPend_reg;
  logic [7:0] wrIdx_reg;
  logic [31:0] hrdata_reg;
  logic [39:0] sync1_reg;
  logic [39:0] sync2_reg;
  logic [39:0] sync3_reg;
  logic [39:0] level_reg;
  logic [39:0] padOut_reg;
  logic [39:0] padOeN_reg;
  logic [39:0] own_reg;

  ////////////////////////////////////////////////////////////////////
  // bus decode

  wire addrPhase = hsel & htrans[1] & hready;
  wire inRange = (haddr[31:10] == 22'h000000);
  wire [7:0] addrIdx = haddr[9:2];
  wire rdReq = addrPhase & ~hwrite & inRange;
  wire wrReq = addrPhase & hwrite & inRange;
  wire [7:0] wrByte = hwdata[7:0];

  wire [39:0] latchFlat = {dataLatch_reg[4], dataLatch_reg[3],
    dataLatch_reg[2], dataLatch_reg[1], dataLatch_reg[0]};
  wire [39:0] dirFlat = {dir_reg[4], dir_reg[3], dir_reg[2],
    dir_reg[1], dir_reg[0]};
  wire [39:0] portView = (dirFlat & latchFlat) | (~dirFlat & level_reg);

  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    case (addrIdx)
      ppc_pkg::IDX_PORTA_DATA: rdByte = portView[7:0];
      ppc_pkg::IDX_PORTB_DATA: rdByte = portView[15:8];
      ppc_pkg::IDX_PORTC_DATA: rdByte = portView[23:16];
      ppc_pkg::IDX_PORTD_DATA: rdByte = portView[31:24];
      ppc_pkg::IDX_PORTE_DATA: rdByte = portView[39:32];
      ppc_pkg::IDX_PORTA_DIR: rdByte = dir_reg[0];
      ppc_pkg::IDX_PORTB_DIR: rdByte = dir_reg[1];
      ppc_pkg::IDX_PORTC_DIR: rdByte = dir_reg[2];
      ppc_pkg::IDX_PORTD_DIR: rdByte = dir_reg[3];
      ppc_pkg::IDX_PORTE_DIR: rdByte = dir_reg[4];
      ppc_pkg::IDX_KEY_IRQ_ENABLE:
        rdByte = {4'h0, cfg_reg.keyIrqPinEnable};
      ppc_pkg::IDX_ADC_STATUS_CONTROL:
        rdByte = {3'h0, cfg_reg.adcChannelSelect};
      ppc_pkg::IDX_TIMER1_CH0_SC:
        rdByte = {4'h0, cfg_reg.timerEdgeLevelSelect[1:0], 2'h0};
      ppc_pkg::IDX_TIMER1_CH1_SC:
        rdByte = {4'h0, cfg_reg.timerEdgeLevelSelect[3:2], 2'h0};
      ppc_pkg::IDX_TIMER2_CH0_SC:
        rdByte = {4'h0, cfg_reg.timerEdgeLevelSelect[5:4], 2'h0};
      ppc_pkg::IDX_TIMER2_CH1_SC:
        rdByte = {4'h0, cfg_reg.timerEdgeLevelSelect[7:6], 2'h0};
      ppc_pkg::IDX_PORTB_HIGH_CURRENT:
        rdByte = {6'h00, cfg_reg.periodicIrqClockSource};
      ppc_pkg::IDX_LCD_CONTROL: rdByte = {7'h00, cfg_reg.lcdDriveEnable};
      ppc_pkg::IDX_SECOND_CONFIG:
        rdByte = {4'h0, cfg_reg.porteLcdEnable, cfg_reg.portdLcdEnable,
          cfg_reg.portcHighLcdEnable, cfg_reg.portcLowLcdEnable};
      default: rdByte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // configuration write

  ppc_pkg::ppc_cfg_t cfg_next;
  always_comb begin
    cfg_next = cfg_reg;
    if (wrPend_reg) begin
      case (wrIdx_reg)
        ppc_pkg::IDX_KEY_IRQ_ENABLE:
          cfg_next.keyIrqPinEnable = wrByte[ppc_pkg::KEY_EN_LSB +: 4];
        ppc_pkg::IDX_ADC_STATUS_CONTROL:
          cfg_next.adcChannelSelect = wrByte[ppc_pkg::ADC_SEL_LSB +: 5];
        ppc_pkg::IDX_TIMER1_CH0_SC:
          cfg_next.timerEdgeLevelSelect[1:0] =
            wrByte[ppc_pkg::TIMER_ELS_LSB +: 2];
        ppc_pkg::IDX_TIMER1_CH1_SC:
          cfg_next.timerEdgeLevelSelect[3:2] =
            wrByte[ppc_pkg::TIMER_ELS_LSB +: 2];
        ppc_pkg::IDX_TIMER2_CH0_SC:
          cfg_next.timerEdgeLevelSelect[5:4] =
            wrByte[ppc_pkg::TIMER_ELS_LSB +: 2];
        ppc_pkg::IDX_TIMER2_CH1_SC:
          cfg_next.timerEdgeLevelSelect[7:6] =
            wrByte[ppc_pkg::TIMER_ELS_LSB +: 2];
        ppc_pkg::IDX_PORTB_HIGH_CURRENT:
          cfg_next.periodicIrqClockSource =
            wrByte[ppc_pkg::PPI_SRC_LSB +: 2];
        ppc_pkg::IDX_LCD_CONTROL:
          cfg_next.lcdDriveEnable = wrByte[ppc_pkg::LCD_EN_BIT];
        ppc_pkg::IDX_SECOND_CONFIG: begin
          cfg_next.portcLowLcdEnable = wrByte[ppc_pkg::PORTC_LOW_LCD_ENABLE_BIT];
          cfg_next.portcHighLcdEnable = wrByte[ppc_pkg::PORTC_HIGH_LCD_ENABLE_BIT];
          cfg_next.portdLcdEnable = wrByte[ppc_pkg::PDE_BIT];
          cfg_next.porteLcdEnable = wrByte[ppc_pkg::PEE_BIT];
        end
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin ownership

  wire [4:0] adcSel = cfg_reg.adcChannelSelect;
  wire [7:0] els = cfg_reg.timerEdgeLevelSelect;
  wire lcdOn = cfg_reg.lcdDriveEnable;
  wire ppiPin = (cfg_reg.periodicIrqClockSource == ppc_pkg::PPI_SRC_PIN);
  wire [3:0] keyOwn = cfg_reg.keyIrqPinEnable;
  wire [5:0] adcOwn;
  wire [3:0] timerOwn;

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gAdc
      assign adcOwn[g] = (adcSel == 5'(g));
    end
    for (g = 0; g < 4; g++) begin : gTim
      assign timerOwn[g] = (els[2*g +: 2] != 2'h0);
    end
  endgenerate

  wire ppiOwn = ppiPin & ~timerOwn[0];
  wire [39:0] ownNext = {
    {8{lcdOn & cfg_reg.porteLcdEnable}},
    {8{lcdOn & cfg_reg.portdLcdEnable}},
    2'h0,
    {2{lcdOn & cfg_reg.portcHighLcdEnable}},
    {4{lcdOn & cfg_reg.portcLowLcdEnable}},
    {2{lcdOn}},
    timerOwn[3:1], timerOwn[0] | ppiOwn,
    adcOwn[5:4],
    adcOwn[3:0],
    keyOwn
  };
  // input-only owners never drive the pin
  wire [39:0] inputOnly = {29'h0, ppiOwn, adcOwn, keyOwn};
  wire [39:0] driveNext = (ownNext & periphDriveEn & ~inputOnly) |
    (~ownNext & dirFlat);
  wire [39:0] outNext = (ownNext & periphDrive) | (~ownNext & latchFlat);
  // per-pin filter, a pin moves once stages 2 and 3 agree
  wire [39:0] syncAgree = ~(sync2_reg ^ sync3_reg);
  wire [39:0] levelNext = (syncAgree & sync3_reg) |
    (~syncAgree & level_reg);

  ////////////////////////////////////////////////////////////////////
  // sequential

  // write data follows in the next cycle, so keep the address phase
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPend_reg <= 1'b0;
      wrIdx_reg <= 8'h00;
    end else begin
      wrPend_reg <= wrReq;
      wrIdx_reg <= addrIdx;
    end
  end

  // read data stands for the data phase only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hrdata_reg <= 32'h00000000;
    end else begin
      hrdata_reg <= rdReq ? {24'h000000, rdByte} : 32'h00000000;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_reg <= ppc_pkg::CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  generate
    for (g = 0; g < ppc_pkg::NPORT; g++) begin : gPort
      wire wrData = wrPend_reg & (wrIdx_reg == 8'(g));
      wire wrDir = wrPend_reg &
        (wrIdx_reg == 8'(g + ppc_pkg::NPORT));
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          dataLatch_reg[g] <= ppc_pkg::BYTE_RESET;
          dir_reg[g] <= ppc_pkg::BYTE_RESET;
        end else begin
          if (wrData) begin
            dataLatch_reg[g] <= wrByte;
          end
          if (wrDir) begin
            dir_reg[g] <= wrByte;
          end
        end
      end
    end
  endgenerate

  // three-stage sync on pins
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 40'h0000000000;
      sync2_reg <= 40'h0000000000;
      sync3_reg <= 40'h0000000000;
    end else begin
      sync1_reg <= padIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      level_reg <= 40'h0000000000;
    end else begin
      level_reg <= levelNext;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      padOut_reg <= 40'h0000000000;
    end else begin
      padOut_reg <= outNext;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      padOeN_reg <= 40'hFFFFFFFFFF;
    end else begin
      padOeN_reg <= ~driveNext;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      own_reg <= 40'h0000000000;
    end else begin
      own_reg <= ownNext;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign padOut = padOut_reg;
  assign padOeN = padOeN_reg;
  assign pinLevel = level_reg;
  assign periphOwn = own_reg;

endmodule

// >>> core/ppc_pkg.sv
/*
  Package for the port pin-sharing control block: register indices,
  field positions, reset values and the configuration carrier.
  Assumes a 32-bit AHB-Lite bus where each register index sits at
  byte address four times the index.
*/
package ppc_pkg;

  localparam int NPORT = 5;
  localparam int NPIN = 40;
  localparam int IDXW = 8;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_PORTA_DATA = 8'h00;
  localparam logic [7:0] IDX_PORTB_DATA = 8'h01;
  localparam logic [7:0] IDX_PORTC_DATA = 8'h02;
  localparam logic [7:0] IDX_PORTD_DATA = 8'h03;
  localparam logic [7:0] IDX_PORTE_DATA = 8'h04;
  localparam logic [7:0] IDX_PORTA_DIR = 8'h05;
  localparam logic [7:0] IDX_PORTB_DIR = 8'h06;
  localparam logic [7:0] IDX_PORTC_DIR = 8'h07;
  localparam logic [7:0] IDX_PORTD_DIR = 8'h08;
  localparam logic [7:0] IDX_PORTE_DIR = 8'h09;
  localparam logic [7:0] IDX_PORTB_HIGH_CURRENT = 8'h0C;
  localparam logic [7:0] IDX_KEY_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] IDX_SECOND_CONFIG = 8'h1D;
  localparam logic [7:0] IDX_TIMER1_CH0_SC = 8'h25;
  localparam logic [7:0] IDX_TIMER1_CH1_SC = 8'h28;
  localparam logic [7:0] IDX_TIMER2_CH0_SC = 8'h30;
  localparam logic [7:0] IDX_TIMER2_CH1_SC = 8'h33;
  localparam logic [7:0] IDX_ADC_STATUS_CONTROL = 8'h3C;
  localparam logic [7:0] IDX_LCD_CONTROL = 8'h51;

  // field positions
  localparam int KEY_EN_LSB = 0;
  localparam int ADC_SEL_LSB = 0;
  localparam int TIMER_ELS_LSB = 2;
  localparam int PPI_SRC_LSB = 0;
  localparam int LCD_EN_BIT = 0;
  localparam int PORTC_LOW_LCD_ENABLE_BIT = 0;
  localparam int PORTC_HIGH_LCD_ENABLE_BIT = 1;
  localparam int PDE_BIT = 2;
  localparam int PEE_BIT = 3;

  // encodings and reset values
  localparam logic [1:0] PPI_SRC_PIN = 2'h1;
  localparam logic [4:0] ADC_SEL_RESET = 5'h1F;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef struct packed {
    logic [3:0] keyIrqPinEnable;
    logic [4:0] adcChannelSelect;
    logic [7:0] timerEdgeLevelSelect;
    logic [1:0] periodicIrqClockSource;
    logic lcdDriveEnable;
    logic portcLowLcdEnable;
    logic portcHighLcdEnable;
    logic portdLcdEnable;
    logic porteLcdEnable;
  } ppc_cfg_t;

  localparam ppc_cfg_t CFG_RESET = '{
    keyIrqPinEnable: 4'h0,
    adcChannelSelect: ADC_SEL_RESET,
    timerEdgeLevelSelect: 8'h00,
    periodicIrqClockSource: 2'h0,
    lcdDriveEnable: 1'b0,
    portcLowLcdEnable: 1'b0,
    portcHighLcdEnable: 1'b0,
    portdLcdEnable: 1'b0,
    porteLcdEnable: 1'b0
  };

endpackage

// >>> dv/ppc_pad_model.sv
/*
  Far side of the block: pads and peripheral drive requests.
  Assumes the bench sets the level of every pad left undriven.
*/
module ppc_pad_model (
  input wire logic [39:0] padOut,
  input wire logic [39:0] padOeN,
  input wire logic [39:0] extLevel,
  input wire logic [39:0] drvPattern,
  input wire logic [39:0] drvWant,
  output logic [39:0] padIn,
  output logic [39:0] periphDrive,
  output logic [39:0] periphDriveEn
);
  timeunit 1ns;
  timeprecision 1ps;
  // driven pad reads back, else outside level
  assign padIn = (padOut & ~padOeN) | (extLevel & padOeN);
  assign periphDrive = drvPattern;
  assign periphDriveEn = drvWant;
endmodule

// >>> dv/ppc_pin_share_sva.sv
/*
  Checker for the pin-sharing block, watching its ports only.
  Assumes one clock domain and an asynchronous active-low reset.
*/
module ppc_pin_share_sva (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [39:0] padIn,
  input wire logic [39:0] padOut,
  input wire logic [39:0] padOeN,
  input wire logic [39:0] periphDrive,
  input wire logic [39:0] periphDriveEn,
  input wire logic [39:0] pinLevel,
  input wire logic [39:0] periphOwn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // pins a timer or the lcd may drive, except pin 10
  localparam logic [39:0] DRV = 40'hFF_FF3F_F800;
  logic [39:0] drvOwn;
  assign drvOwn = periphOwn & periphDriveEn & DRV;
  sequence s_pads_quiet;
    $stable(padIn) [*6];
  endsequence
  sequence s_drive_quiet;
    ($stable(periphDrive) && $stable(drvOwn)) [*3];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_owned_input: assert property (
    (periphOwn[9:0] & ~padOeN[9:0]) == 10'h0)
    else $error("key or adc pin is driven");
  a_portc_free: assert property (periphOwn[23:22] == 2'b00)
    else $error("port c top pins taken");
  a_pin_sync: assert property (
    s_pads_quiet |-> pinLevel == padIn)
    else $error("pin level does not follow pad");
  a_reset_input: assert property (
    $rose(nrst) |-> padOeN == 40'hFF_FFFF_FFFF)
    else $error("pin driven after reset");
  a_adc_onehot: assert property (
    $onehot0({periphOwn[9:8], periphOwn[7:4]}))
    else $error("more than one adc pin owned");
  a_periph_value: assert property (
    s_drive_quiet |-> ((padOut ^ periphDrive) & drvOwn) == 40'h0)
    else $error("peripheral value not on pin");
  a_periph_oe: assert property (
    s_drive_quiet |-> (padOeN & drvOwn) == 40'h0)
    else $error("peripheral pin not driven");
endmodule

// >>> dv/tb_port_pin_sharing_control.sv
/*
  Testbench for the pin-sharing block: owner table, data path, overrides.
  Assumes a zero-wait AHB-Lite slave and the pad model on the far side.
*/
module tb_port_pin_sharing_control;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] val;
    logic [7:0] back;
    logic [39:0] own;
  } ppc_row_t;
  logic clock, nrst, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [39:0] padIn, padOut, padOeN, periphDrive, periphDriveEn;
  logic [39:0] pinLevel, periphOwn, extLevel, drvPattern, drvWant;
  int n_errors = 0;
  int check_count = 0;
  ppc_row_t rows [18];
  ppc_pin_share uut (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .padIn, .padOut, .padOeN, .periphDrive, .periphDriveEn, .pinLevel,
    .periphOwn);
  ppc_pad_model pads (.padOut, .padOeN, .extLevel, .drvPattern,
    .drvWant, .padIn, .periphDrive, .periphDriveEn);
  //////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
    input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    tick(1);
    while (hreadyout !== 1'b1) tick(1);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    tick(1);
    while (hreadyout !== 1'b1) tick(1);
    rd = hrdata;
  endtask
  task automatic compare(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic read_check(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 8'h00);
    compare({8'h0, rd}, {8'h0, e});
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #100000;
    n_errors++;
    stop_test;
  end
  initial begin
    {nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    extLevel = 40'hA5_5A3C_C3A5;
    drvPattern = 40'h96_6996_6996;
    drvWant = 40'hFF_FFFF_FFFF;
    rows = '{'{8'h1C, 8'h05, 8'h00, 40'h5}, '{8'h3C, 8'h00, 8'h1F, 40'h10},
      '{8'h3C, 8'h03, 8'h1F, 40'h80}, '{8'h3C, 8'h04, 8'h1F, 40'h100},
      '{8'h3C, 8'h05, 8'h1F, 40'h200}, '{8'h3C, 8'h06, 8'h1F, 40'h0},
      '{8'h25, 8'h04, 8'h00, 40'h400}, '{8'h28, 8'h08, 8'h00, 40'h800},
      '{8'h30, 8'h0C, 8'h00, 40'h1000}, '{8'h33, 8'h04, 8'h00, 40'h2000},
      '{8'h0C, 8'h01, 8'h00, 40'h400}, '{8'h1D, 8'h0F, 8'h00, 40'h0},
      '{8'h51, 8'h01, 8'h01, 40'hC000}, '{8'h1D, 8'h01, 8'h00, 40'hF_C000},
      '{8'h1D, 8'h02, 8'h00, 40'h30_C000},
      '{8'h1D, 8'h04, 8'h00, 40'hFF00_C000},
      '{8'h1D, 8'h08, 8'h00, 40'hFF_0000_C000},
      '{8'h51, 8'h00, 8'h00, 40'h0}};
    tick(12);
    nrst <= 1'b1;
    tick(1);
    compare(padOeN, 40'hFF_FFFF_FFFF);
    compare(periphOwn, 40'h0);
    read_check(8'h05, 32'h0);
    read_check(8'h3C, 32'h1F);
    read_check(8'h00, 32'hA5);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].val);
      tick(2);
      compare(periphOwn, rows[i].own);
      bus(1'b1, rows[i].idx, rows[i].back);
    end
    $display("test owner table done");
    bus(1'b1, 8'h0C, 8'h01);
    tick(2);
    compare({39'h0, padOeN[10]}, 40'h1);
    bus(1'b1, 8'h25, 8'h04);
    tick(2);
    compare({39'h0, padOeN[10]}, 40'h0);
    bus(1'b1, 8'h25, 8'h00);
    bus(1'b1, 8'h0C, 8'h00);
    $display("test periodic clock pin done");
    // latch written while still an input
    bus(1'b1, 8'h00, 8'h3C);
    bus(1'b1, 8'h05, 8'h0F);
    tick(6);
    compare({28'h0, padOeN[7:0], padOut[3:0]}, 40'hF0C);
    read_check(8'h00, 32'hAC);
    bus(1'b1, 8'h05, 8'hFF);
    bus(1'b1, 8'h1C, 8'h01);
    bus(1'b1, 8'h3C, 8'h00);
    tick(2);
    compare({32'h0, padOeN[7:0]}, 40'h11);
    bus(1'b1, 8'h1C, 8'h00);
    bus(1'b1, 8'h3C, 8'h1F);
    $display("test direction and override done");
    bus(1'b1, 8'h51, 8'h01);
    bus(1'b1, 8'h1D, 8'h03);
    bus(1'b1, 8'h07, 8'hC0);
    bus(1'b1, 8'h02, 8'h40);
    tick(4);
    compare({24'h0, padOeN[23:16], padOut[23:16]}, 40'h56);
    read_check(8'h02, 32'h56);
    bus(1'b1, 8'hFF, 8'hAA);
    read_check(8'hFF, 32'h0);
    $display("test lcd and unmapped done");
    nrst <= 1'b0;
    tick(2);
    compare(padOeN, 40'hFF_FFFF_FFFF);
    compare(periphOwn, 40'h0);
    nrst <= 1'b1;
    tick(1);
    read_check(8'h07, 32'h0);
    $display("test reset again done");
    stop_test;
  end
endmodule

bind ppc_pin_share ppc_pin_share_sva chk (.clock, .nrst, .hreadyout,
  .hresp, .hrdata, .padIn, .padOut, .padOeN, .periphDrive,
  .periphDriveEn, .pinLevel, .periphOwn);
